// ===== design/core_regs_pkg.sv
/*
 * constants for the core status and timer/prescaler configuration registers:
 * bit positions, reset values and widths.
 * assumes the core's execution unit drives the control strobes described
 * in the module that uses this package.
 */
package core_regs_pkg;

    // --------------------------------------------------------------------
    // status register bit positions
    // --------------------------------------------------------------------
    localparam int STAT_CARRY_BIT = 0;
    localparam int STAT_NIBBLE_BIT = 1;
    localparam int STAT_ZERO_BIT = 2;
    localparam int STAT_SLEEP_N_BIT = 3;
    localparam int STAT_WDOG_N_BIT = 4;
    localparam int STAT_PAGE_BIT = 5;
    localparam int STAT_CMP_WAKE_BIT = 6;
    localparam int STAT_PIN_WAKE_BIT = 7;

    // --------------------------------------------------------------------
    // configuration register bit positions
    // --------------------------------------------------------------------
    localparam int CFG_PULL_DIS_BIT = 6;
    localparam int CFG_WAKE_DIS_BIT = 7;

    // --------------------------------------------------------------------
    // widths and reset values
    // --------------------------------------------------------------------
    localparam int REG_WIDTH = 8;
    localparam int PC_PAGE_BIT = 9;
    localparam logic [7:0] CFG_RESET_VAL = 8'hFF;
    localparam logic [2:0] ALU_FLAGS_RESET = 3'h0;

    // reset cause codes presented by the reset controller
    typedef enum logic [1:0]
    {
        CAUSE_POWER = 2'h0,
        CAUSE_OTHER = 2'h1,
        CAUSE_PIN_WAKE = 2'h3,
        CAUSE_CMP_WAKE = 2'h2
    } reset_cause_e;

endpackage : core_regs_pkg

// ===== design/core_status_option_regs.sv
/*
 * status register and write-only timer/prescaler configuration register
 * of the processor core, plus the pin-direction gating of the pin-change
 * wake-up and weak pull-up enables.
 * assumes the execution unit presents one-cycle strobes in clk_in domain,
 * that the reset controller holds reset_cause_in stable while
 * init_pulse_in is high, and that all inputs except nrst_in are synchronous to clk_in.
 */
//
// How it works
// - status accepts writes like any file register, except timeout and power-down bits 4, 3
// - alu flag instructions keep computed zero, nibble, carry
// - timeout and power-down flags ignore instruction writes
// - file clear zeroes top three, sets zero
// - bit ops and moves write flags exactly
// - zero flag reflects alu result equals zero
// - config register write-only, loaded from working register
// - every reset sets config to all ones
// - output direction forces wake, pull-up off
// - page bit drives program counter bit nine
// - any reset clears page select bit
// - config bits 7, 6 disable wake, pull-ups
`timescale 1ns/10ps

module core_status_option_regs
    import core_regs_pkg::*;
#(
    parameter int PIN_COUNT = 6 // port pins with wake and pull-up
)
(
    input wire logic clk_in, // 40 MHz instruction-side clock
    input wire logic nrst_in, // asynchronous, active low
    input wire logic init_pulse_in, // one cycle: a reset just ended
    input wire logic [1:0] reset_cause_in, // reset_cause_e, held in init
    input wire logic file_write_in, // status is write destination
    input wire logic [7:0] file_wdata_in, // value written to status
    input wire logic file_clear_instr_in, // clear of status
    input wire logic alu_flag_update_in, // instruction sets alu flags
    input wire logic [2:0] alu_flag_mask_in, // which of c, dc, z it sets
    input wire logic alu_carry_in, // computed carry
    input wire logic alu_nibble_in, // computed nibble carry
    input wire logic [7:0] alu_result_in, // alu result for zero test
    input wire logic watchdog_kick_instr_in, // watchdog kick executed
    input wire logic sleep_instr_in, // sleep executed
    input wire logic watchdog_timeout_in, // watchdog expired
    input wire logic config_load_instr_in, // load config from w
    input wire logic [7:0] w_reg_in, // working register
    input wire logic [PIN_COUNT-1:0] pin_direction_bits_in, // 0 = output
    output logic [7:0] core_status_flags_out, // status read value
    output logic page_select_bit_out, // program counter bit nine
    output logic [7:0] timer_prescaler_config_out, // timer side only
    output logic [PIN_COUNT-1:0] pin_wake_enable_out, // per-pin wake on
    output logic [PIN_COUNT-1:0] weak_pull_enable_out // per-pin pull on
);

    // --------------------------------------------------------------------
    // state
    // --------------------------------------------------------------------
    logic pin_wake_reset_flag_reg; // bit 7
    logic pin_wake_reset_flag_next;
    logic comparator_wake_reset_flag_reg; // bit 6
    logic comparator_wake_reset_flag_next;
    logic page_select_bit_reg; // bit 5
    logic page_select_bit_next;
    logic watchdog_expired_n_reg; // bit 4, low after timeout
    logic watchdog_expired_n_next;
    logic sleep_entered_n_reg; // bit 3, low after sleep
    logic sleep_entered_n_next;
    logic [2:0] alu_flags_reg; // z, dc, c in bits 2..0
    logic [2:0] alu_flags_next;
    logic [7:0] timer_prescaler_config_reg; // write-only config
    logic [7:0] timer_prescaler_config_next;
    logic result_zero; // zero test of alu result

    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    // per-pin enable: function on only if enabled and pin is an input
    function automatic logic [PIN_COUNT-1:0] gate_by_dir
    (
        input logic disable_bit,
        input logic [PIN_COUNT-1:0] dir
    );
        gate_by_dir = disable_bit ? '0 : dir;
    endfunction : gate_by_dir

    assign result_zero = (alu_result_in == 8'h00);

    // --------------------------------------------------------------------
    // next-state of status bits
    // --------------------------------------------------------------------
    // priority: reset-end capture, then file clear, then plain write,
    // then alu flag update; alu result wins over written value in the masked bits only
    always_comb
    begin
        pin_wake_reset_flag_next = pin_wake_reset_flag_reg;
        comparator_wake_reset_flag_next = comparator_wake_reset_flag_reg;
        page_select_bit_next = page_select_bit_reg;
        watchdog_expired_n_next = watchdog_expired_n_reg;
        sleep_entered_n_next = sleep_entered_n_reg;
        alu_flags_next = alu_flags_reg;
        if (init_pulse_in)
        begin
            // wake causes latched after reset release, not in async reset
            pin_wake_reset_flag_next =
                (reset_cause_in == CAUSE_PIN_WAKE);
            comparator_wake_reset_flag_next =
                (reset_cause_in == CAUSE_CMP_WAKE);
            page_select_bit_next = 1'b0;
            if (reset_cause_in == CAUSE_POWER)
            begin
                watchdog_expired_n_next = 1'b1;
                sleep_entered_n_next = 1'b1;
            end
        end
        else if (file_clear_instr_in)
        begin
            // upper three cleared, zero set, others untouched
            pin_wake_reset_flag_next = 1'b0;
            comparator_wake_reset_flag_next = 1'b0;
            page_select_bit_next = 1'b0;
            alu_flags_next[STAT_ZERO_BIT] = 1'b1;
        end
        else if (file_write_in)
        begin
            // writable bits land as given; timeout/sleep bits untouched
            pin_wake_reset_flag_next =
                file_wdata_in[STAT_PIN_WAKE_BIT];
            comparator_wake_reset_flag_next =
                file_wdata_in[STAT_CMP_WAKE_BIT];
            page_select_bit_next = file_wdata_in[STAT_PAGE_BIT];
            alu_flags_next = file_wdata_in[2:0];
        end
        // alu flags overwrite the written value for affected bits
        if (alu_flag_update_in && !init_pulse_in && !file_clear_instr_in)
        begin
            if (alu_flag_mask_in[STAT_CARRY_BIT])
                alu_flags_next[STAT_CARRY_BIT] = alu_carry_in;
            if (alu_flag_mask_in[STAT_NIBBLE_BIT])
                alu_flags_next[STAT_NIBBLE_BIT] = alu_nibble_in;
            if (alu_flag_mask_in[STAT_ZERO_BIT])
                alu_flags_next[STAT_ZERO_BIT] = result_zero;
        end
        // hardware-only events for timeout and power-down flags
        if (watchdog_kick_instr_in)
        begin
            watchdog_expired_n_next = 1'b1;
            sleep_entered_n_next = 1'b1;
        end
        else if (sleep_instr_in)
        begin
            watchdog_expired_n_next = 1'b1;
            sleep_entered_n_next = 1'b0;
        end
        // a timeout is never lost to a same-cycle kick or sleep
        if (watchdog_timeout_in)
            watchdog_expired_n_next = 1'b0;
    end

    // --------------------------------------------------------------------
    // status registers
    // --------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pin_wake_reset_flag_reg <= 1'b0;
            comparator_wake_reset_flag_reg <= 1'b0;
            page_select_bit_reg <= 1'b0;
            watchdog_expired_n_reg <= 1'b1;
            sleep_entered_n_reg <= 1'b1;
            alu_flags_reg <= ALU_FLAGS_RESET;
        end
        else
        begin
            pin_wake_reset_flag_reg <= pin_wake_reset_flag_next;
            comparator_wake_reset_flag_reg <= comparator_wake_reset_flag_next;
            page_select_bit_reg <= page_select_bit_next;
            watchdog_expired_n_reg <= watchdog_expired_n_next;
            sleep_entered_n_reg <= sleep_entered_n_next;
            alu_flags_reg <= alu_flags_next;
        end
    end

    // --------------------------------------------------------------------
    // configuration register
    // --------------------------------------------------------------------
    // only the dedicated instruction and init load it; there is no read path
    always_comb
    begin
        timer_prescaler_config_next = timer_prescaler_config_reg;
        if (init_pulse_in)
            timer_prescaler_config_next = CFG_RESET_VAL;
        else if (config_load_instr_in)
            timer_prescaler_config_next = w_reg_in;
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            timer_prescaler_config_reg <= CFG_RESET_VAL;
        else
            timer_prescaler_config_reg <= timer_prescaler_config_next;
    end

    // --------------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------------
    assign core_status_flags_out = {pin_wake_reset_flag_reg,
                                    comparator_wake_reset_flag_reg,
                                    page_select_bit_reg,
                                    watchdog_expired_n_reg,
                                    sleep_entered_n_reg,
                                    alu_flags_reg};
    assign page_select_bit_out = page_select_bit_reg;
    assign timer_prescaler_config_out = timer_prescaler_config_reg;
    // direction override beats the disable bits
    assign pin_wake_enable_out = gate_by_dir(
        timer_prescaler_config_reg[CFG_WAKE_DIS_BIT],
        pin_direction_bits_in);
    assign weak_pull_enable_out = gate_by_dir(
        timer_prescaler_config_reg[CFG_PULL_DIS_BIT],
        pin_direction_bits_in);

endmodule : core_status_option_regs

// ===== verif/core_regs_assertions.sv
/* checker for the core status and configuration registers.
   assumes it is bound to core_status_option_regs, one clock. */
`timescale 1ns/10ps
module core_regs_assertions
    import core_regs_pkg::*;
#(parameter int PIN_COUNT = 6)
(
    input wire logic clk_in, nrst_in, init_pulse_in,
    input wire logic [1:0] reset_cause_in,
    input wire logic file_write_in, file_clear_instr_in,
    input wire logic [7:0] file_wdata_in, alu_result_in, w_reg_in,
    input wire logic alu_flag_update_in, alu_carry_in, alu_nibble_in,
    input wire logic [2:0] alu_flag_mask_in,
    input wire logic watchdog_kick_instr_in, sleep_instr_in,
    input wire logic watchdog_timeout_in, config_load_instr_in,
    input wire logic [PIN_COUNT-1:0] pin_direction_bits_in,
    input wire logic [7:0] core_status_flags_out,
    input wire logic [7:0] timer_prescaler_config_out,
    input wire logic page_select_bit_out,
    input wire logic [PIN_COUNT-1:0] pin_wake_enable_out,
    input wire logic [PIN_COUNT-1:0] weak_pull_enable_out
);
    // ----------------------------------------------------------------
    // steps that start a checked behaviour
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence plain_write_s;
        file_write_in && !alu_flag_update_in && !file_clear_instr_in
            && !init_pulse_in;
    endsequence
    sequence alu_update_s;
        alu_flag_update_in && !file_clear_instr_in && !init_pulse_in;
    endsequence
    sequence hw_quiet_s;
        !watchdog_kick_instr_in && !sleep_instr_in && !watchdog_timeout_in
            && !init_pulse_in;
    endsequence
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    write_lands_a: assert property (plain_write_s |=>
        {core_status_flags_out[7:5], core_status_flags_out[2:0]} ==
        $past({file_wdata_in[7:5], file_wdata_in[2:0]}))
        else $error("status write did not land");
    flags_locked_a: assert property (file_write_in and hw_quiet_s |=>
        core_status_flags_out[4:3] == $past(core_status_flags_out[4:3]))
        else $error("timeout or power-down bit took a write");
    alu_zero_a: assert property (alu_update_s and alu_flag_mask_in[2] |=>
        core_status_flags_out[2] == ($past(alu_result_in) == 8'h00))
        else $error("zero flag wrong");
    alu_carry_a: assert property (alu_update_s and alu_flag_mask_in[0] |=>
        core_status_flags_out[0] == $past(alu_carry_in))
        else $error("carry flag not from alu");
    alu_nibble_a: assert property (alu_update_s and alu_flag_mask_in[1] |=>
        core_status_flags_out[1] == $past(alu_nibble_in))
        else $error("nibble flag not from alu");
    clear_file_a: assert property (file_clear_instr_in && !init_pulse_in
        |=> core_status_flags_out[7:5] == 3'h0 && core_status_flags_out[2]
        && $stable(core_status_flags_out[1:0]))
        else $error("status clear wrong");
    config_load_a: assert property (config_load_instr_in && !init_pulse_in
        |=> timer_prescaler_config_out == $past(w_reg_in))
        else $error("config not loaded from w");
    cause_flags_a: assert property (init_pulse_in |=>
        core_status_flags_out[7] == ($past(reset_cause_in) == CAUSE_PIN_WAKE)
        && core_status_flags_out[6] ==
        ($past(reset_cause_in) == CAUSE_CMP_WAKE)
        && !core_status_flags_out[5]
        && timer_prescaler_config_out == CFG_RESET_VAL)
        else $error("reset cause or reset values wrong");
    sleep_flags_a: assert property (sleep_instr_in && !watchdog_kick_instr_in
        && !watchdog_timeout_in && !init_pulse_in
        |=> core_status_flags_out[4:3] == 2'h2)
        else $error("sleep flags wrong");
    timeout_flag_a: assert property (watchdog_timeout_in && !init_pulse_in
        |=> !core_status_flags_out[4])
        else $error("timeout flag not cleared");
    page_out_a: assert property (page_select_bit_out ==
        core_status_flags_out[5])
        else $error("page output differs from status");
    pin_gate_a: assert property (pin_wake_enable_out == (pin_direction_bits_in
        & {PIN_COUNT{!timer_prescaler_config_out[7]}}) && weak_pull_enable_out
        == (pin_direction_bits_in & {PIN_COUNT{!timer_prescaler_config_out[6]}}))
        else $error("wake or pull enable gating wrong");
endmodule : core_regs_assertions

bind core_status_option_regs core_regs_assertions #(.PIN_COUNT(PIN_COUNT))
    u_chk (.*);

// ===== verif/exec_unit_model.sv
/* model of the execution unit: one operation code a cycle becomes
   the register block's strobes. assumes op_in changes at negedge. */
`timescale 1ns/10ps
module exec_unit_model
(
    input wire logic [3:0] op_in, // operation, 0 idles
    input wire logic [7:0] val_in, // w, alu result or new bit values
    input wire logic [7:0] aux_in, // bit mask, or alu {n, c, mask}
    input wire logic [7:0] status_in, // status read back for bit ops
    output logic fw_out, fc_out, au_out, ac_out, an_out,
    output logic kick_out, slp_out, tmo_out, cl_out, ini_out,
    output logic [7:0] wd_out, res_out, w_out,
    output logic [2:0] msk_out
);
    // ----------------------------------------------------------------
    // decode: 1 move, 2 bit op, 3 clear, 4 alu to status, 5 kick,
    // 6 sleep, 7 timeout, 8 config load, 9 init, A alu to w
    // ----------------------------------------------------------------
    always_comb
    begin
        // status written as a file register only by moves, bit ops and alu to status
        fw_out = (op_in == 4'h1) || (op_in == 4'h2) || (op_in == 4'h4);
        // bit op is read-modify-write of the live status value
        wd_out = (op_in == 4'h2) ? ((status_in & ~aux_in) | (val_in & aux_in))
            : val_in;
        fc_out = (op_in == 4'h3);
        au_out = (op_in == 4'h4) || (op_in == 4'hA);
        msk_out = aux_in[2:0];
        ac_out = aux_in[3];
        an_out = aux_in[4];
        res_out = val_in;
        kick_out = (op_in == 4'h5);
        slp_out = (op_in == 4'h6);
        tmo_out = (op_in == 4'h7);
        cl_out = (op_in == 4'h8);
        w_out = val_in;
        ini_out = (op_in == 4'h9);
    end
endmodule : exec_unit_model

// ===== verif/tb_top.sv
/* testbench for core_status_option_regs with the execution unit model.
   assumes inputs change at negedge and outputs settle by the next. */
`timescale 1ns/10ps
`define CHK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            $display("Error %s expected %h seen %h", what, exp, got); \
            num_errors++; \
        end \
    end
module tb_top;
    import core_regs_pkg::*;
    logic clk = 1'b0, nrst = 1'b0; // clock and active-low reset
    logic [1:0] cause = 2'h0; // reset cause for init
    logic [5:0] dir = 6'h2A; // pins 1, 3, 5 inputs
    logic [3:0] op = 4'h0; // operation to the model
    logic [7:0] val = 8'h00, aux = 8'h00; // its operands
    int num_errors = 0, n_compared = 0;
    wire fw, fc, au, ac, an, kick, slp, tmo, cl, ini, page;
    wire [7:0] wd, res, w, st, cfg;
    wire [2:0] msk;
    wire [5:0] wake, pull;
    exec_unit_model u_exec (.op_in(op), .val_in(val), .aux_in(aux),
        .status_in(st), .fw_out(fw), .fc_out(fc), .au_out(au), .ac_out(ac),
        .an_out(an), .kick_out(kick), .slp_out(slp), .tmo_out(tmo),
        .cl_out(cl), .ini_out(ini), .wd_out(wd), .res_out(res), .w_out(w),
        .msk_out(msk));
    core_status_option_regs #(.PIN_COUNT(6)) u_dut (.clk_in(clk),
        .nrst_in(nrst), .init_pulse_in(ini), .reset_cause_in(cause),
        .file_write_in(fw), .file_wdata_in(wd), .file_clear_instr_in(fc),
        .alu_flag_update_in(au), .alu_flag_mask_in(msk), .alu_carry_in(ac),
        .alu_nibble_in(an), .alu_result_in(res), .watchdog_kick_instr_in(kick),
        .sleep_instr_in(slp), .watchdog_timeout_in(tmo),
        .config_load_instr_in(cl), .w_reg_in(w), .pin_direction_bits_in(dir),
        .core_status_flags_out(st), .page_select_bit_out(page),
        .timer_prescaler_config_out(cfg), .pin_wake_enable_out(wake),
        .weak_pull_enable_out(pull));
    // ----------------------------------------------------------------
    // clock, tasks and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic do_reset();
        nrst = 1'b0;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
    endtask : do_reset
    // one operation for one cycle, then the result is settled
    task automatic exec(input logic [3:0] o, input logic [7:0] v, a);
        op = o;
        val = v;
        aux = a;
        @(negedge clk);
        op = 4'h0;
    endtask : exec
    task automatic rd(input string what, input logic [7:0] exp);
        `CHK(what, exp, st)
    endtask : rd
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        #50000;
        num_errors++;
        complete_run();
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        do_reset();
        rd("status in reset", 8'h18);
        `CHK("config in reset", 8'hFF, cfg)
        exec(4'h9, 8'h00, 8'h00);
        rd("status after init", 8'h18);
        $display("test reset done");
        exec(4'h8, 8'h3F, 8'h00);
        `CHK("config load", 8'h3F, cfg)
        `CHK("wake enables", 6'h2A, wake)
        `CHK("pull enables", 6'h2A, pull)
        exec(4'h8, 8'h80, 8'h00);
        `CHK("wake disabled", 6'h00, wake)
        dir = 6'h00;
        @(negedge clk);
        `CHK("pull on outputs", 6'h00, pull)
        dir = 6'h2A;
        $display("test config done");
        exec(4'h1, 8'hE7, 8'h00);
        rd("move to status", 8'hFF);
        `CHK("page output", 1'b1, page)
        exec(4'h1, 8'h00, 8'h00);
        rd("locked flags", 8'h18);
        exec(4'h1, 8'hE7, 8'h00);
        exec(4'h3, 8'h00, 8'h00);
        rd("file clear", 8'h1F);
        exec(4'h4, 8'h05, 8'h1F);
        rd("alu to status", 8'h1B);
        exec(4'hA, 8'h00, 8'h04);
        rd("zero result", 8'h1F);
        exec(4'h2, 8'hFF, 8'h20);
        rd("bit set", 8'h3F);
        exec(4'h2, 8'h00, 8'h01);
        rd("bit clear", 8'h3E);
        $display("test status done");
        exec(4'h6, 8'h00, 8'h00);
        rd("sleep", 8'h36);
        exec(4'h7, 8'h00, 8'h00);
        rd("timeout", 8'h26);
        exec(4'h5, 8'h00, 8'h00);
        rd("kick", 8'h3E);
        $display("test events done");
        for (int c = 0; c < 4; c++)
        begin
            exec(4'h8, 8'h00, 8'h00);
            do_reset();
            cause = c[1:0];
            exec(4'h9, 8'h00, 8'h00);
            rd("cause flags", {c == 3, c == 2, 6'h18});
            `CHK("config reset", 8'hFF, cfg)
        end
        $display("test causes done");
        complete_run();
    end
endmodule : tb_top
